// ==== tg_tone_gen.sv ====
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps

module tg_tone_gen
(
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [tg_pkg::ADDR_W-1:0] ADDR,
    input wire logic [tg_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [tg_pkg::DATA_W-1:0] RDATA,
    input wire logic TONE_SRC_CLK,
    output logic [4:0] DAC0_CODE,
    output logic DAC0_OE,
    output logic [4:0] DAC1_CODE,
    output logic DAC1_OE,
    output logic [6:0] SERIES_RES_SW,
    output logic OVP_ROUTE_SW,
    output logic ROUTE_RES_B,
    output logic ROUTE_RES_A,
    output logic MIDPOINT_EDGE,
    output logic IRQ
);
    import tg_pkg::*;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    function automatic logic [4:0] dac0_pick(input logic [2:0] sel,
                                             input logic [4:0] clamped);
        case (sel)
            SEL_CLAMP: dac0_pick = clamped;
            SEL_HI: dac0_pick = CLAMP_HI;
            SEL_MID: dac0_pick = CODE_MID;
            SEL_LO: dac0_pick = CLAMP_LO;
            default: dac0_pick = CODE_ZERO;
        endcase
    endfunction

    logic [7:0] preload_value;
    logic gen_enable;
    logic dac0_enable;
    logic dac1_enable;
    logic [6:0] series_resistor_switches;
    logic [2:0] dac0_source_code;
    logic [4:0] dac1_code_field;
    logic ovp_route_switch;
    logic route_resistor_switch_b;
    logic route_resistor_switch_a;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;

    tg_state_e state;
    logic tick;
    logic [7:0] div;
    logic [7:0] period_preload;
    logic [5:0] phase;
    logic [4:0] count;
    logic dir_down;
    logic [4:0] clamped;
    logic step;
    logic boundary;
    logic [IRQ_W-1:0] irq_set;

    ////////////////////////////////////////////////////////////////////////
    // tone clock enters the system domain

    tg_sync u_sync
    (
        .clk(SYS_CLK),
        .rst(RST),
        .async_in(TONE_SRC_CLK),
        .rise(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // register file

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            preload_value <= 8'h00;
            gen_enable <= 1'b0;
            dac0_enable <= 1'b0;
            dac1_enable <= 1'b0;
            series_resistor_switches <= SERIES_RESET;
            dac0_source_code <= 3'h0;
            dac1_code_field <= 5'h00;
            ovp_route_switch <= 1'b0;
            route_resistor_switch_b <= 1'b0;
            route_resistor_switch_a <= 1'b0;
            irq_mask <= '0;
        end
        else if (WR)
        begin
            // while running, a new preload waits in this register until period end
            if (hit(ADDR, OFF_PRELOAD))
                preload_value <= WDATA;
            if (hit(ADDR, OFF_CONTROL))
            begin
                gen_enable <= WDATA[CTL_GEN_EN];
                dac0_enable <= WDATA[CTL_DAC0_EN];
                dac1_enable <= WDATA[CTL_DAC1_EN];
            end
            if (hit(ADDR, OFF_SERIES))
                series_resistor_switches <= WDATA[6:0];
            if (hit(ADDR, OFF_DAC0_SEL))
                dac0_source_code <= WDATA[2:0];
            if (hit(ADDR, OFF_DAC1))
                dac1_code_field <= WDATA[4:0];
            if (hit(ADDR, OFF_ROUTE))
            begin
                ovp_route_switch <= WDATA[RT_OVP];
                route_resistor_switch_b <= WDATA[RT_RES_B];
                route_resistor_switch_a <= WDATA[RT_RES_A];
            end
            if (hit(ADDR, OFF_IRQ_MASK))
                irq_mask <= WDATA[IRQ_W-1:0];
        end
    end

    // unmapped addresses read as zero
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
            RDATA <= 8'h00;
        else if (RD)
        begin
            case (ADDR)
                OFF_PRELOAD: RDATA <= preload_value;
                OFF_CONTROL: RDATA <= {5'h00, dac1_enable, dac0_enable,
                                       gen_enable};
                OFF_SERIES: RDATA <= {1'b0, series_resistor_switches};
                OFF_DAC0_SEL: RDATA <= {5'h00, dac0_source_code};
                OFF_DAC1: RDATA <= {3'h0, dac1_code_field};
                OFF_ROUTE: RDATA <= {5'h00, ovp_route_switch,
                                     route_resistor_switch_b,
                                     route_resistor_switch_a};
                OFF_IRQ_STATUS: RDATA <= {6'h00, irq_status};
                OFF_IRQ_MASK: RDATA <= {6'h00, irq_mask};
                default: RDATA <= 8'h00;
            endcase
        end
        else
            RDATA <= 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // divider, triangle counter and clamp

    // no tick arrives while the source clock is halted, so divider and counter stand still while running
    assign step = tick && (state == ST_RUN) && (div == DIV_MAX);
    // the period end and the midpoint edge fall on the same step
    assign boundary = step && (phase == PHASE_BEFORE_MID);
    // top phase bit is the direction, so the counter steers itself
    assign dir_down = phase[5];
    assign count = dir_down ? ~phase[4:0] : phase[4:0];

    always_comb
    begin
        clamped = count;
        // the turn at 1fh and 00h spans both directions, so clamp both ways
        if (count > CLAMP_HI)
            clamped = CLAMP_HI;
        else if (count < CLAMP_LO)
            clamped = CLAMP_LO;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
            state <= ST_IDLE;
        else
        begin
            case (state)
                ST_IDLE:
                    if (gen_enable)
                        state <= ST_RUN;
                ST_RUN:
                    // re-enabling before the boundary keeps it running
                    if (boundary && !gen_enable)
                        state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            div <= 8'h00;
            period_preload <= 8'h00;
            phase <= PHASE_MID;
        end
        else if (state != ST_RUN)
        begin
            div <= preload_value;
            period_preload <= preload_value;
            phase <= PHASE_MID;
        end
        else if (tick)
        begin
            if (div == DIV_MAX)
            begin
                phase <= phase + 6'h01;
                // 64 steps of (256 - preload) ticks each
                if (boundary)
                begin
                    div <= preload_value;
                    period_preload <= preload_value;
                end
                else
                    div <= period_preload;
            end
            else
                div <= div + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            DAC0_CODE <= CODE_ZERO;
            DAC0_OE <= 1'b0;
            DAC1_CODE <= CODE_ZERO;
            DAC1_OE <= 1'b0;
            SERIES_RES_SW <= SERIES_RESET;
            OVP_ROUTE_SW <= 1'b0;
            ROUTE_RES_B <= 1'b0;
            ROUTE_RES_A <= 1'b0;
            MIDPOINT_EDGE <= 1'b0;
        end
        else
        begin
            DAC0_CODE <= dac0_pick(dac0_source_code, clamped);
            DAC0_OE <= dac0_enable;
            DAC1_CODE <= dac1_code_field;
            DAC1_OE <= dac1_enable;
            SERIES_RES_SW <= series_resistor_switches;
            OVP_ROUTE_SW <= ovp_route_switch;
            ROUTE_RES_B <= route_resistor_switch_b;
            ROUTE_RES_A <= route_resistor_switch_a;
            MIDPOINT_EDGE <= boundary;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts: set wins over a write-one clear in the same cycle

    always_comb
    begin
        irq_set = '0;
        irq_set[IRQ_MIDPOINT] = boundary;
        irq_set[IRQ_STOPPED] = boundary && !gen_enable;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
            irq_status <= '0;
        else if (WR && hit(ADDR, OFF_IRQ_STATUS))
            irq_status <= (irq_status & ~WDATA[IRQ_W-1:0]) | irq_set;
        else
            irq_status <= irq_status | irq_set;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
            IRQ <= 1'b0;
        else
            IRQ <= |(irq_status & irq_mask);
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);

    a_idle_preload: assert property (
        (state == ST_IDLE && $past(state) == ST_IDLE && !$past(RST))
        |-> div == $past(preload_value))
        else $error("divider did not track preload while idle");

    a_start_mid: assert property (
        $rose(state == ST_RUN) |-> count == CODE_MID && !dir_down)
        else $error("counting did not start at midpoint");

    a_idle_hold: assert property (
        state == ST_IDLE |-> count == CODE_MID)
        else $error("counter not held at midpoint while idle");

    a_clamp_high: assert property (
        (dac0_source_code == SEL_CLAMP && count > CLAMP_HI)
        |=> DAC0_CODE == CLAMP_HI)
        else $error("peak value not clamped");

    a_clamp_low: assert property (
        (dac0_source_code == SEL_CLAMP && count < CLAMP_LO)
        |=> DAC0_CODE == CLAMP_LO)
        else $error("trough value not clamped");

    a_edge_pulse: assert property (
        (step && phase == PHASE_BEFORE_MID) |=> MIDPOINT_EDGE ##1
        !MIDPOINT_EDGE)
        else $error("midpoint edge pulse wrong");

    a_period_reload: assert property (
        boundary |=> div == $past(preload_value) &&
        period_preload == $past(preload_value))
        else $error("divider not reloaded at period end");

    a_stop_boundary: assert property (
        (state == ST_RUN && boundary && !gen_enable) |=> state == ST_IDLE)
        else $error("did not stop at period end");

    a_run_keeps: assert property (
        (state == ST_RUN && !boundary) |=> state == ST_RUN)
        else $error("stopped away from period end");

    a_dac0_const: assert property (
        dac0_source_code == SEL_HI |=> DAC0_CODE == CLAMP_HI)
        else $error("dac0 constant selection wrong");

    a_series_reset: assert property (
        ($past(RST) && !$past(WR)) |-> SERIES_RES_SW == SERIES_RESET)
        else $error("series switches not on after reset");

    a_irq_level: assert property (
        |(irq_status & irq_mask) |=> IRQ)
        else $error("interrupt not raised");

    c_run_start: cover property ($rose(state == ST_RUN));
    c_midpoint: cover property (MIDPOINT_EDGE);
    c_stop: cover property ($fell(state == ST_RUN));
    c_irq: cover property ($rose(IRQ));
endmodule

// ==== tg_sync.sv ====
// Summary of operation
// - divider overflow steps the 5-bit triangle counter
// - counter spans 00h..1Fh, direction from its own bit
// - clamp rising above 1Ch, falling below 03h
// - enable low: preload goes straight into divider
// - enable high: reload only at period end
// - enable high: counting starts from 0Fh
// - enable cleared: finish period, then hold 0Fh
// - period is (256 - preload) times 64 ticks
// - one edge pulse at 0Fh while counting up
// - stop at period end; re-enable keeps running
// - dac0 source code selects clamp or constant
// - dac1 driven from written 5-bit code
// - each dac has enable; disabled output floats
// - seven series switches, all on after reset
// - route bit 2 ovp path, bits 1..0 resistors
// - tone clock stops when its source stops

`timescale 1ns/1ps

package tg_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [3:0] OFF_PRELOAD = 4'h0;
    localparam logic [3:0] OFF_CONTROL = 4'h1;
    localparam logic [3:0] OFF_SERIES = 4'h2;
    localparam logic [3:0] OFF_DAC0_SEL = 4'h3;
    localparam logic [3:0] OFF_DAC1 = 4'h4;
    localparam logic [3:0] OFF_ROUTE = 4'h5;
    localparam logic [3:0] OFF_IRQ_STATUS = 4'h6;
    localparam logic [3:0] OFF_IRQ_MASK = 4'h7;
    // control register fields
    localparam int CTL_GEN_EN = 0;
    localparam int CTL_DAC0_EN = 1;
    localparam int CTL_DAC1_EN = 2;
    // route register fields
    localparam int RT_RES_A = 0;
    localparam int RT_RES_B = 1;
    localparam int RT_OVP = 2;
    // interrupt status fields
    localparam int IRQ_W = 2;
    localparam int IRQ_MIDPOINT = 0;
    localparam int IRQ_STOPPED = 1;
    localparam logic [6:0] SERIES_RESET = 7'h7f;
    localparam logic [7:0] DIV_MAX = 8'hff;
    localparam logic [5:0] PHASE_MID = 6'h0f;
    localparam logic [5:0] PHASE_BEFORE_MID = 6'h0e;
    localparam logic [4:0] CODE_MID = 5'h0f;
    localparam logic [4:0] CLAMP_HI = 5'h1c;
    localparam logic [4:0] CLAMP_LO = 5'h03;
    localparam logic [4:0] CODE_ZERO = 5'h00;
    localparam logic [2:0] SEL_CLAMP = 3'h0;
    localparam logic [2:0] SEL_HI = 3'h1;
    localparam logic [2:0] SEL_MID = 3'h2;
    localparam logic [2:0] SEL_LO = 3'h3;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } tg_state_e;
endpackage

module tg_sync
(
    input wire logic clk,
    input wire logic rst,
    input wire logic async_in,
    output logic rise
);
    logic meta;
    logic stable;
    logic stable_d;

    // only the second stage reads meta; the edge detector never looks at it
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta <= 1'b0;
            stable <= 1'b0;
            stable_d <= 1'b0;
            rise <= 1'b0;
        end
        else
        begin
            meta <= async_in;
            stable <= meta;
            stable_d <= stable;
            rise <= stable & ~stable_d;
        end
    end
endmodule

// ==== tg_tone_src.sv ====
`timescale 1ns/1ps

module tg_tone_src
(
    input wire logic run,
    output logic tone_clk
);
    // 600 ns period, offset so it has no phase tie to the system clock;
    // each level lasts 3 system cycles, above the sync chain minimum
    initial
    begin
        tone_clk = 1'b0;
        #37;
        forever
        begin
            #300;
            // a stopped source parks the clock low, as in halt
            if (run)
                tone_clk = ~tone_clk;
            else
                tone_clk = 1'b0;
        end
    end
endmodule

// ==== tg_tone_gen_tb_top.sv ====
`timescale 1ns/1ps

module tg_tone_gen_tb_top;
    import tg_pkg::*;
    logic SYS_CLK = 1'b0;
    logic RST = 1'b1;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [ADDR_W-1:0] ADDR = '0;
    logic [DATA_W-1:0] WDATA = '0;
    logic src_run = 1'b1;
    wire logic tone_clk;
    wire logic [DATA_W-1:0] RDATA;
    wire logic [4:0] DAC0_CODE;
    wire logic [4:0] DAC1_CODE;
    wire logic [6:0] SERIES_RES_SW;
    wire logic DAC0_OE, DAC1_OE, OVP_ROUTE_SW, ROUTE_RES_B, ROUTE_RES_A;
    wire logic MIDPOINT_EDGE, IRQ;
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int last_t = 0;
    int n = 0;
    int bad = 0;
    logic [4:0] cmax, cmin;
    logic [7:0] exp_c;

    initial
    begin
        forever #50 SYS_CLK = ~SYS_CLK;
    end

    always @(posedge SYS_CLK) cyc <= cyc + 1;

    tg_tone_src src (.run(src_run), .tone_clk(tone_clk));

    tg_tone_gen dut (.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .TONE_SRC_CLK(tone_clk), .DAC0_CODE(DAC0_CODE),
        .DAC0_OE(DAC0_OE), .DAC1_CODE(DAC1_CODE), .DAC1_OE(DAC1_OE),
        .SERIES_RES_SW(SERIES_RES_SW), .OVP_ROUTE_SW(OVP_ROUTE_SW),
        .ROUTE_RES_B(ROUTE_RES_B), .ROUTE_RES_A(ROUTE_RES_A),
        .MIDPOINT_EDGE(MIDPOINT_EDGE), .IRQ(IRQ));

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        if (n_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge SYS_CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge SYS_CLK);
        WR <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge SYS_CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge SYS_CLK);
        RD <= 1'b0;
        #1;
        chk(RDATA, exp);
    endtask

    // interval is taken from the free cycle count, so bus traffic between
    // two calls does not disturb the measured period
    task automatic wait_mid(output int len);
        int k;
        k = 0;
        cmax = 5'h00;
        cmin = 5'h1f;
        do
        begin
            @(posedge SYS_CLK);
            #1;
            k++;
            if (DAC0_CODE > cmax) cmax = DAC0_CODE;
            if (DAC0_CODE < cmin) cmin = DAC0_CODE;
        end
        while (MIDPOINT_EDGE !== 1'b1 && k < 2000);
        if (k >= 2000)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: no midpoint pulse", $time);
            wrap_up();
        end
        len = cyc - last_t;
        last_t = cyc;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge SYS_CLK);
        RST <= 1'b0;
        rd(OFF_PRELOAD, 8'h00);
        rd(OFF_CONTROL, 8'h00);
        rd(OFF_SERIES, 8'h7f);
        rd(OFF_DAC0_SEL, 8'h00);
        rd(OFF_DAC1, 8'h00);
        rd(OFF_ROUTE, 8'h00);
        rd(OFF_IRQ_STATUS, 8'h00);
        rd(OFF_IRQ_MASK, 8'h00);
        rd(4'h9, 8'h00);
        chk({1'b0, SERIES_RES_SW}, 8'h7f);
        chk({6'h00, DAC0_OE, DAC1_OE}, 8'h00);
        wr(OFF_SERIES, 8'h2a);
        wr(OFF_ROUTE, 8'h05);
        wr(OFF_DAC1, 8'h3a);
        wr(OFF_CONTROL, 8'h06);
        wr(4'hb, 8'hff);
        @(posedge SYS_CLK);
        #1;
        chk({1'b0, SERIES_RES_SW}, 8'h2a);
        chk({5'h00, OVP_ROUTE_SW, ROUTE_RES_B, ROUTE_RES_A}, 8'h05);
        chk({3'h0, DAC1_CODE}, 8'h1a);
        chk({6'h00, DAC0_OE, DAC1_OE}, 8'h03);
        rd(OFF_DAC1, 8'h1a);
        rd(4'hb, 8'h00);
        for (int i = 1; i < 8; i++)
        begin
            wr(OFF_DAC0_SEL, 8'(i));
            @(posedge SYS_CLK);
            #1;
            exp_c = (i == 1) ? 8'h1c : (i == 2) ? 8'h0f
                  : (i == 3) ? 8'h03 : 8'h00;
            chk({3'h0, DAC0_CODE}, exp_c);
        end
        // start with the source stopped so the first code can be seen
        src_run <= 1'b0;
        wr(OFF_DAC0_SEL, 8'h00);
        wr(OFF_PRELOAD, 8'hff);
        wr(OFF_IRQ_MASK, 8'h01);
        wr(OFF_CONTROL, 8'h07);
        repeat (4) @(posedge SYS_CLK);
        #1;
        chk({3'h0, DAC0_CODE}, 8'h0f);
        repeat (60) @(posedge SYS_CLK);
        #1;
        chk({3'h0, DAC0_CODE}, 8'h0f);
        chk({7'h00, MIDPOINT_EDGE}, 8'h00);
        src_run <= 1'b1;
        wait_mid(n);
        wait_mid(n);
        chk(8'(n / 8), 8'd48);
        chk({3'h0, cmax}, 8'h1c);
        chk({3'h0, cmin}, 8'h03);
        @(posedge SYS_CLK);
        #1;
        chk({7'h00, MIDPOINT_EDGE}, 8'h00);
        chk({7'h00, IRQ}, 8'h01);
        rd(OFF_IRQ_STATUS, 8'h01);
        wr(OFF_IRQ_STATUS, 8'h01);
        @(posedge SYS_CLK);
        #1;
        chk({7'h00, IRQ}, 8'h00);
        wait_mid(n);
        wr(OFF_PRELOAD, 8'hfe);
        wait_mid(n);
        chk(8'(n / 8), 8'd48);
        wait_mid(n);
        chk(8'(n / 8), 8'd96);
        wr(OFF_IRQ_MASK, 8'h00);
        wait_mid(n);
        @(posedge SYS_CLK);
        #1;
        chk({7'h00, IRQ}, 8'h00);
        rd(OFF_IRQ_STATUS, 8'h01);
        // enable dropped and restored inside one period
        wr(OFF_CONTROL, 8'h06);
        wr(OFF_CONTROL, 8'h07);
        wait_mid(n);
        wait_mid(n);
        chk(8'(n / 8), 8'd96);
        wr(OFF_CONTROL, 8'h06);
        wait_mid(n);
        repeat (3) @(posedge SYS_CLK);
        rd(OFF_IRQ_STATUS, 8'h03);
        bad = 0;
        repeat (800)
        begin
            @(posedge SYS_CLK);
            #1;
            if (MIDPOINT_EDGE !== 1'b0 || DAC0_CODE !== 5'h0f) bad++;
        end
        chk({7'h00, bad != 0}, 8'h00);
        // idle write of preload, then restart; the next full period must use it
        wr(OFF_PRELOAD, 8'hff);
        wr(OFF_CONTROL, 8'h01);
        @(posedge SYS_CLK);
        #1;
        chk({6'h00, DAC0_OE, DAC1_OE}, 8'h00);
        wait_mid(n);
        wait_mid(n);
        chk(8'(n / 8), 8'd48);
        wrap_up();
    end
endmodule
